// ### adc_conversion_control.sv
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_control
  import adc_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] compare_unit_mode,
  input wire logic special_event_trig,
  input wire logic sleep_active,
  input wire logic comparator_in,
  input wire logic rc_osc_in,
  output logic irq,
  output logic event_timer_clear,
  output logic wake_request,
  output logic converter_enable,
  output logic conversion_busy,
  output logic [3:0] channel_select,
  output logic [RES_BITS-1:0] dac_code,
  output logic [7:0] config_out,
  output logic [3:0] vref_control
);

  typedef struct packed {
    conv_state_e state;
    logic go;
    logic pwr;
    logic [1:0] clksel;
    logic [3:0] chan;
    logic [7:0] cfg;
    logic [3:0] vref;
    logic flag;
    logic irq_en;
    logic global_irq_enable;
    logic peripheral_irq_enable;
    logic [4:0] div_cnt;
    logic tad_hi;
    logic [3:0] idx;
    logic [RES_BITS-1:0] sar;
    logic [2:0] wait_cnt;
    logic sleep_off;
    logic wake;
    logic tmr_clr;
    logic cmp_s1;
    logic cmp_s2;
    logic rc_s1;
    logic rc_s2;
    logic rc_s3;
    logic ack;
    logic err;
    logic [31:0] rdata;
  } state_s;

  state_s st_ff;
  state_s nxt_st;
  logic [RES_BITS-1:0] result_ff;
  logic [RES_BITS-1:0] nxt_result;
  logic result_load;
  logic tad_rise;
  logic tad_fall;
  logic div_tick;
  logic [4:0] half;
  logic wr_take;
  logic acc;
  logic start;
  logic trig_ok;
  logic [3:0] pos;
  logic [RES_BITS-1:0] trial_mask;

  // Register hit test on an aligned word address
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    i = a[ADDR_W-1:2];
    addr_hit = (a[1:0] == 2'h0) && (i == IDX_INT_GLOBAL || i == IDX_PERIPH_FLAG ||
               i == IDX_RESULT_HIGH || i == IDX_CTRL_MAIN || i == IDX_PERIPH_EN ||
               i == IDX_VREF_CTRL || i == IDX_RESULT_LOW || i == IDX_CTRL_CFG);
  endfunction

  // Conversion clock half period per select code
  function automatic logic [4:0] tad_half(input logic [1:0] sel);
    case (sel)
      2'h0: tad_half = TAD_HALF_00;
      2'h1: tad_half = TAD_HALF_01;
      default: tad_half = TAD_HALF_10;
    endcase
  endfunction

  // Result placement in the high and low bytes
  function automatic logic [15:0] result_split(input logic [RES_BITS-1:0] r,
                                               input logic right);
    if (right) begin
      result_split = {4'h0, r};
    end else begin
      result_split = {r, 4'h0};
    end
  endfunction

  // Read mux of the register map
  function automatic logic [7:0] read_reg(input logic [7:0] i, input state_s s,
                                          input logic [RES_BITS-1:0] r);
    logic [15:0] sp;
    sp = result_split(r, s.cfg[FORMAT_BIT]);
    case (i)
      IDX_INT_GLOBAL: read_reg = {s.global_irq_enable, s.peripheral_irq_enable, 6'h00};
      IDX_PERIPH_FLAG: read_reg = {1'b0, s.flag, 6'h00};
      IDX_PERIPH_EN: read_reg = {1'b0, s.irq_en, 6'h00};
      IDX_RESULT_HIGH: read_reg = sp[15:8];
      IDX_RESULT_LOW: read_reg = sp[7:0];
      IDX_CTRL_MAIN: read_reg = {s.clksel, s.chan[2:0], s.go, s.chan[3], s.pwr};
      IDX_CTRL_CFG: read_reg = s.cfg;
      IDX_VREF_CTRL: read_reg = {s.vref, 4'h0};
      default: read_reg = 8'h00;
    endcase
  endfunction

  // Conversion clock edges: divided oscillator or resynchronised RC source
  always_comb begin
    half = tad_half(st_ff.clksel);
    div_tick = (st_ff.div_cnt == half - 5'h01);
    if (st_ff.clksel == CLKSEL_RC) begin
      tad_rise = st_ff.rc_s2 && !st_ff.rc_s3;
      tad_fall = !st_ff.rc_s2 && st_ff.rc_s3;
    end else begin
      tad_rise = div_tick && !st_ff.tad_hi;
      tad_fall = div_tick && st_ff.tad_hi;
    end
  end

  // Bit under trial; meaningful only while bits are resolving
  assign pos = 4'(IDX_LAST_BIT - st_ff.idx);
  assign trial_mask = (st_ff.idx >= IDX_FIRST_BIT && st_ff.idx <= IDX_LAST_BIT) ?
                      (RES_BITS'(1) << pos) : '0;
  assign acc = psel && penable && st_ff.ack;
  assign wr_take = acc && pwrite && addr_hit(paddr);
  assign trig_ok = special_event_trig && compare_unit_mode == TRIG_MODE && st_ff.pwr;

  // Next state of the whole block
  always_comb begin
    nxt_st = st_ff;
    nxt_result = result_ff;
    result_load = 1'b0;
    start = 1'b0;
    nxt_st.wake = 1'b0;
    // Two sync flops on the comparator and RC inputs; at code 00 the comparator answer lags a period
    nxt_st.cmp_s1 = comparator_in;
    nxt_st.cmp_s2 = st_ff.cmp_s1;
    nxt_st.rc_s1 = rc_osc_in;
    nxt_st.rc_s2 = st_ff.rc_s1;
    nxt_st.rc_s3 = st_ff.rc_s2;
    nxt_st.tmr_clr = special_event_trig;

    // Bus slave: one wait state so read data comes from a flop
    nxt_st.ack = psel && penable && !st_ff.ack;
    nxt_st.err = psel && penable && !st_ff.ack && !addr_hit(paddr);
    if (psel && penable && !st_ff.ack) begin
      nxt_st.rdata = {24'h0, read_reg(paddr[ADDR_W-1:2], st_ff, result_ff)};
    end

    // Divider runs only during a conversion on the oscillator
    if (st_ff.state == ST_CONV && st_ff.clksel != CLKSEL_RC) begin
      nxt_st.div_cnt = div_tick ? 5'h00 : st_ff.div_cnt + 5'h01;
      nxt_st.tad_hi = div_tick ? !st_ff.tad_hi : st_ff.tad_hi;
    end else begin
      nxt_st.div_cnt = 5'h00;
      nxt_st.tad_hi = 1'b0;
    end

    // Conversion sequence
    case (st_ff.state)
      ST_IDLE: begin
      end
      ST_WAIT: begin
        nxt_st.wait_cnt = st_ff.wait_cnt + 3'h1;
        if (st_ff.wait_cnt == 3'(INSTR_CYC - 1)) begin
          nxt_st.state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (tad_rise && st_ff.idx != IDX_DONE) begin
          nxt_st.idx = st_ff.idx + 4'h1;
          if (st_ff.idx == IDX_FIRST_BIT - 4'h1) begin
            nxt_st.sar = RES_BITS'(1) << (RES_BITS - 1);
          end else if (st_ff.idx >= IDX_FIRST_BIT) begin
            nxt_st.sar[pos] = st_ff.cmp_s2;
            if (pos != 4'h0) begin
              nxt_st.sar[pos - 4'h1] = 1'b1;
            end
          end
          if (st_ff.idx == IDX_LAST_BIT) begin
            // Rise of the 14th period: result and flag
            nxt_result = nxt_st.sar;
            result_load = 1'b1;
            nxt_st.flag = 1'b1;
            if (sleep_active) begin
              nxt_st.wake = st_ff.irq_en;
              nxt_st.sleep_off = !st_ff.irq_en;
            end
          end
        end
        if (tad_fall && st_ff.idx == IDX_DONE) begin
          nxt_st.go = 1'b0;
          nxt_st.state = ST_IDLE;
        end
      end
      default: nxt_st.state = ST_IDLE;
    endcase

    // Software register writes
    if (wr_take) begin
      case (paddr[ADDR_W-1:2])
        IDX_INT_GLOBAL: begin
          nxt_st.global_irq_enable = pwdata[GIE_BIT];
          nxt_st.peripheral_irq_enable = pwdata[PERIPHERAL_IRQ_ENABLE_BIT];
        end
        IDX_PERIPH_FLAG: begin
          if (pwdata[DONE_FLAG_BIT] && !(nxt_st.flag && !st_ff.flag)) begin
            nxt_st.flag = 1'b0;
          end
        end
        IDX_PERIPH_EN: nxt_st.irq_en = pwdata[DONE_FLAG_BIT];
        IDX_VREF_CTRL: nxt_st.vref = pwdata[7:4];
        IDX_CTRL_CFG: nxt_st.cfg = pwdata[7:0];
        IDX_CTRL_MAIN: begin
          nxt_st.clksel = pwdata[7:6];
          nxt_st.chan = {pwdata[CHAN3_BIT], pwdata[5:3]};
          nxt_st.pwr = pwdata[POWER_BIT];
          if (!pwdata[GO_BIT] && st_ff.state != ST_IDLE) begin
            // Early halt keeps only the resolved bits
            nxt_st.go = 1'b0;
            nxt_st.state = ST_IDLE;
            if (st_ff.state == ST_CONV) begin
              nxt_result = st_ff.sar & ~trial_mask;
              result_load = 1'b1;
            end
          end else if (pwdata[GO_BIT] && st_ff.state == ST_IDLE) begin
            // Power-up and go together would convert on a cold core
            start = st_ff.pwr && pwdata[POWER_BIT];
          end
        end
        default: begin
        end
      endcase
    end

    // Compare-unit trigger; channel must already be chosen by software
    if (trig_ok && st_ff.state == ST_IDLE) begin
      start = 1'b1;
    end

    if (start) begin
      nxt_st.go = 1'b1;
      nxt_st.state = (nxt_st.clksel == CLKSEL_RC) ? ST_WAIT : ST_CONV;
      nxt_st.idx = 4'h0;
      nxt_st.sar = '0;
      nxt_st.wait_cnt = 3'h0;
      nxt_st.div_cnt = 5'h00;
      nxt_st.tad_hi = 1'b0;
    end

    // Powering off or sleeping on the oscillator clock kills the conversion
    if (!nxt_st.pwr || (sleep_active && st_ff.clksel != CLKSEL_RC)) begin
      nxt_st.go = 1'b0;
      nxt_st.state = ST_IDLE;
      result_load = result_load && nxt_st.pwr;
    end
    if (sleep_active && st_ff.clksel != CLKSEL_RC) begin
      nxt_st.sleep_off = 1'b1;
    end
    if (!sleep_active) begin
      nxt_st.sleep_off = 1'b0;
    end
  end

  // All control state; constants only under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Result holds across resets, so it has no reset branch
  always_ff @(posedge pclk) begin
    if (result_load) begin
      result_ff <= nxt_result;
    end
  end

  // Outputs
  assign prdata = st_ff.rdata;
  assign pready = st_ff.ack;
  assign pslverr = st_ff.err;
  assign irq = st_ff.flag && st_ff.irq_en && st_ff.peripheral_irq_enable && st_ff.global_irq_enable;
  assign event_timer_clear = st_ff.tmr_clr;
  assign wake_request = st_ff.wake;
  assign converter_enable = st_ff.pwr && !st_ff.sleep_off;
  assign conversion_busy = st_ff.go;
  assign channel_select = st_ff.chan;
  assign dac_code = st_ff.sar;
  assign config_out = st_ff.cfg;
  assign vref_control = st_ff.vref;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_last_rise;
    st_ff.state == ST_CONV && tad_rise && st_ff.idx == IDX_LAST_BIT;
  endsequence

  sequence s_done_fall;
    st_ff.flag ##[1:40] !st_ff.go;
  endsequence

  a_trigger_starts: assert property (trig_ok && st_ff.state == ST_IDLE
      && !wr_take && !sleep_active |=> st_ff.go && st_ff.state != ST_IDLE)
    else $error("trigger did not start conversion");

  a_trigger_timer: assert property (special_event_trig |=> event_timer_clear)
    else $error("event timer not cleared on trigger");

  a_unpowered_idle: assert property (special_event_trig && !st_ff.pwr
      && st_ff.state == ST_IDLE && !wr_take |=> !st_ff.go)
    else $error("unpowered converter took trigger");

  a_done_sequence: assert property (s_last_rise |=> s_done_fall)
    else $error("completion flag or go clear missing");

  // Result is the resolved upper bits plus the last synchronised comparator answer
  a_done_result: assert property (s_last_rise and (!sleep_active && !wr_take)
      |=> result_ff == {$past(st_ff.sar[RES_BITS-1:1]), $past(st_ff.cmp_s2)})
    else $error("result not loaded at completion");

  a_abort_partial: assert property (wr_take && paddr[ADDR_W-1:2] == IDX_CTRL_MAIN
      && !pwdata[GO_BIT] && pwdata[POWER_BIT] && st_ff.state == ST_CONV && !sleep_active
      |=> !st_ff.go && result_ff == ($past(st_ff.sar) & ~$past(trial_mask)))
    else $error("abort did not keep resolved bits only");

  a_same_write: assert property (wr_take && paddr[ADDR_W-1:2] == IDX_CTRL_MAIN
      && !st_ff.pwr && pwdata[POWER_BIT] && pwdata[GO_BIT] && !trig_ok |=> !st_ff.go)
    else $error("go kept with power-on in one write");

  // Counted from history, not from the wait counter that drives the state
  a_rc_wait: assert property (st_ff.state == ST_CONV && $past(st_ff.state) == ST_WAIT
      |-> $past(st_ff.state, 4) == ST_WAIT && $past(st_ff.state, 5) == ST_IDLE)
    else $error("rc start delay wrong");

  a_sleep_abort: assert property (sleep_active && st_ff.clksel != CLKSEL_RC
      && st_ff.pwr |=> !st_ff.go && !converter_enable && st_ff.pwr)
    else $error("sleep on oscillator clock did not abort");

  a_sleep_wake: assert property (s_last_rise and (sleep_active
      && st_ff.irq_en && !wr_take) |=> wake_request && converter_enable)
    else $error("no wake after conversion in sleep");

endmodule
`default_nettype wire

// ### adc_conversion_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_control_bench
  import adc_ctrl_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, tclr, wake, cen, busy, cmp, rcc, err, woke;
  logic trig = 1'b0;
  logic slp = 1'b0;
  logic [3:0] mode = 4'h0;
  logic [3:0] chan, vref;
  logic [RES_BITS-1:0] dac;
  logic [RES_BITS-1:0] level = '0;
  logic [7:0] cfg, q;
  int error_cnt = 0;
  int n_tests = 0;
  int cnt;

  always #25 pclk = ~pclk;

  adc_conversion_control DUT (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .compare_unit_mode(mode),
    .special_event_trig(trig),
    .sleep_active(slp),
    .comparator_in(cmp),
    .rc_osc_in(rcc),
    .irq(irq),
    .event_timer_clear(tclr),
    .wake_request(wake),
    .converter_enable(cen),
    .conversion_busy(busy),
    .channel_select(chan),
    .dac_code(dac),
    .config_out(cfg),
    .vref_control(vref)
  );

  sar_core_model core (
    .dac_code(dac),
    .level(level),
    .run(busy),
    .cmp(cmp),
    .rc_clk(rcc)
  );

  task automatic summarize;
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic hang;
    error_cnt++;
    summarize();
  endtask

  // One APB transfer; waits for pready instead of trusting the wait state
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) hang();
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bounded wait on the go bit, also catching any wake pulse
  task automatic wait_busy(input logic v);
    cnt = 0;
    while (busy !== v) begin
      @(posedge pclk);
      woke |= wake;
      cnt++;
      if (cnt > 3000) hang();
    end
  endtask

  task automatic run_conv(input logic [7:0] m, input logic [11:0] lv);
    level = lv;
    bus(1'b1, IDX_CTRL_MAIN, m);
    bus(1'b1, IDX_CTRL_MAIN, m | 8'h04);
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask

  task automatic chk_res(input logic fmt, input logic [11:0] r);
    bus(1'b0, IDX_RESULT_HIGH, 8'h00);
    chk("result_high", q, fmt ? {4'h0, r[11:8]} : r[11:4]);
    bus(1'b0, IDX_RESULT_LOW, 8'h00);
    chk("result_low", q, fmt ? r[7:0] : {r[3:0], 4'h0});
  endtask

  task automatic t_reset;
    logic [7:0] idx [6] = '{IDX_INT_GLOBAL, IDX_PERIPH_FLAG, IDX_CTRL_MAIN,
                            IDX_PERIPH_EN, IDX_VREF_CTRL, IDX_CTRL_CFG};
    foreach (idx[i]) begin
      bus(1'b0, idx[i], 8'h00);
      chk("reset_value", q, RESET_VALUE);
    end
    bus(1'b0, 8'h00, 8'h00);
    chk("unmapped_err", err, 1'b1);
    chk("unmapped_data", q, 8'h00);
    bus(1'b1, IDX_VREF_CTRL, 8'hA0);
    @(posedge pclk);
    chk("vref", vref, 4'hA);
  endtask

  // Clock codes 00, 01 and 10 in both alignments, with the interrupt path
  task automatic t_convert;
    logic [11:0] lv;
    bus(1'b1, IDX_INT_GLOBAL, 8'hC0);
    bus(1'b1, IDX_PERIPH_EN, 8'h40);
    for (int f = 0; f < 2; f++) begin
      for (int c = 0; c < 3; c++) begin
        // Code 00 outruns the comparator sync; only full scale resolves predictably
        lv = (c == 0) ? 12'hFFF : (f ? 12'hA5C : 12'h3F1);
        bus(1'b1, IDX_CTRL_CFG, f ? 8'h80 : 8'h00);
        run_conv({c[1:0], 6'h01}, lv);
        chk("conv_time", cnt >= 13 * (2 << 2 * c) && cnt <= 14 * (2 << 2 * c) + 6, 1'b1);
        chk_res(f[0], lv);
        chk("dac_code", dac, lv);
        chk("config_out", cfg, f ? 8'h80 : 8'h00);
        chk("irq", irq, 1'b1);
        bus(1'b1, IDX_PERIPH_FLAG, 8'h40);
        @(posedge pclk);
        chk("irq_clear", irq, 1'b0);
      end
    end
  endtask

  task automatic t_trigger;
    logic [5:0] cs [3] = '{6'b101111, 6'b101010, 6'b101100};
    logic seen, st;
    foreach (cs[i]) begin
      // Channel chosen before the trigger
      bus(1'b1, IDX_CTRL_MAIN, {7'h14, cs[i][1]});
      mode <= cs[i][5:2];
      @(posedge pclk);
      trig <= 1'b1;
      @(posedge pclk);
      trig <= 1'b0;
      seen = 1'b0;
      st = 1'b0;
      repeat (4) begin
        @(posedge pclk);
        seen |= tclr;
        st |= busy;
      end
      chk("timer_clear", seen, 1'b1);
      chk("trig_start", st, cs[i][0]);
      chk("channel", chan, 4'h5);
      wait_busy(1'b0);
    end
    bus(1'b1, IDX_PERIPH_FLAG, 8'h40);
  endtask

  task automatic t_abort;
    logic [11:0] r, z;
    bus(1'b1, IDX_CTRL_MAIN, 8'h05);
    repeat (3) @(posedge pclk);
    chk("go_with_power", busy, 1'b0);
    bus(1'b0, IDX_CTRL_MAIN, 8'h00);
    chk("go_bit", q, 8'h01);
    bus(1'b1, IDX_CTRL_CFG, 8'h80);
    level = 12'hFFF;
    bus(1'b1, IDX_CTRL_MAIN, 8'h05);
    repeat (10) @(posedge pclk);
    bus(1'b1, IDX_CTRL_MAIN, 8'h01);
    @(posedge pclk);
    chk("abort_busy", busy, 1'b0);
    bus(1'b0, IDX_RESULT_HIGH, 8'h00);
    r[11:8] = q[3:0];
    bus(1'b0, IDX_RESULT_LOW, 8'h00);
    r[7:0] = q;
    z = ~r;
    chk("partial", r != 12'hFFF && r[11], 1'b1);
    chk("unresolved_zero", z & (z + 12'h001), 12'h000);
  endtask

  task automatic t_sleep;
    bus(1'b1, IDX_PERIPH_FLAG, 8'h40);
    bus(1'b1, IDX_CTRL_MAIN, 8'h05);
    @(posedge pclk);
    slp <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("sleep_busy", busy, 1'b0);
    chk("sleep_off", cen, 1'b0);
    bus(1'b0, IDX_CTRL_MAIN, 8'h00);
    chk("power_kept", q[0], 1'b1);
    bus(1'b0, IDX_PERIPH_FLAG, 8'h00);
    chk("no_flag", q, 8'h00);
    slp <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("power_back", cen, 1'b1);
  endtask

  // RC clock chosen for sleep, sleep follows go
  task automatic t_rc;
    for (int e = 1; e >= 0; e--) begin
      bus(1'b1, IDX_PERIPH_EN, e ? 8'h40 : 8'h00);
      bus(1'b1, IDX_PERIPH_FLAG, 8'h40);
      bus(1'b1, IDX_CTRL_MAIN, 8'hC1);
      level = 12'h5A3;
      bus(1'b1, IDX_CTRL_MAIN, 8'hC5);
      slp <= 1'b1;
      woke = 1'b0;
      wait_busy(1'b1);
      wait_busy(1'b0);
      repeat (3) @(posedge pclk);
      woke |= wake;
      chk("wake", woke, e[0]);
      chk("rc_power", cen, e[0]);
      chk("irq_mask", irq, e[0]);
      chk_res(1'b1, 12'h5A3);
      bus(1'b0, IDX_CTRL_MAIN, 8'h00);
      chk("rc_power_bit", q[0], 1'b1);
      slp <= 1'b0;
    end
  endtask

  task automatic t_reset_mid;
    bus(1'b1, IDX_CTRL_MAIN, 8'h01);
    level = 12'h111;
    bus(1'b1, IDX_CTRL_MAIN, 8'h05);
    repeat (6) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset_abort", busy, 1'b0);
    chk("reset_off", cen, 1'b0);
    bus(1'b0, IDX_CTRL_MAIN, 8'h00);
    chk("reset_main", q, RESET_VALUE);
    chk_res(1'b0, 12'h5A3);
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_convert();
    t_trigger();
    t_abort();
    t_sleep();
    t_rc();
    t_reset_mid();
    summarize();
  end
endmodule
`default_nettype wire

// ### adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // Clock and instruction timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int INSTR_CYCLE_NS = 200;
  localparam int INSTR_CYC = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Conversion clock half periods, in oscillator periods
  localparam logic [4:0] TAD_HALF_00 = 5'h01;
  localparam logic [4:0] TAD_HALF_01 = 5'h04;
  localparam logic [4:0] TAD_HALF_10 = 5'h10;
  localparam logic [1:0] CLKSEL_RC = 2'h3;

  // Conversion sequence: one settling period, then twelve bit periods
  localparam int RES_BITS = 12;
  localparam logic [3:0] IDX_FIRST_BIT = 4'h2;
  localparam logic [3:0] IDX_LAST_BIT = 4'hD;
  localparam logic [3:0] IDX_DONE = 4'hE;
  localparam logic [3:0] TRIG_MODE = 4'hB;

  // Register indices; byte address is four times the index
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_INT_GLOBAL = 8'h0B;
  localparam logic [7:0] IDX_PERIPH_FLAG = 8'h0C;
  localparam logic [7:0] IDX_RESULT_HIGH = 8'h1E;
  localparam logic [7:0] IDX_CTRL_MAIN = 8'h1F;
  localparam logic [7:0] IDX_PERIPH_EN = 8'h8C;
  localparam logic [7:0] IDX_VREF_CTRL = 8'h9B;
  localparam logic [7:0] IDX_RESULT_LOW = 8'h9E;
  localparam logic [7:0] IDX_CTRL_CFG = 8'h9F;

  // Field positions
  localparam int GIE_BIT = 7;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int DONE_FLAG_BIT = 6;
  localparam int POWER_BIT = 0;
  localparam int GO_BIT = 2;
  localparam int CHAN3_BIT = 1;
  localparam int FORMAT_BIT = 7;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CONV = 2'b10
  } conv_state_e;

endpackage

// ### sar_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module sar_core_model
  import adc_ctrl_pkg::*;
(
  input wire logic [RES_BITS-1:0] dac_code,
  input wire logic [RES_BITS-1:0] level,
  input wire logic run,
  output logic cmp,
  output var logic rc_clk
);
  // Ideal comparator; except at code 00 the design's sync flops absorb any real lag
  assign cmp = (level >= dac_code);
  // RC clock, unrelated to pclk, still between conversions
  initial rc_clk = 1'b0;
  always #87 rc_clk = run ? ~rc_clk : 1'b0;
endmodule
`default_nettype wire
